// ---- design/amp_ctrl_pkg.sv ----
// constants, field layout and carrier types of the amplifier control bank
// assumes one 8-bit register space reached by byte offset from the port
package amp_ctrl_pkg;

   // register offsets
   localparam logic [7:0] ADDR_IDENT = 8'h00;
   localparam logic [7:0] ADDR_POWER = 8'h01;
   localparam logic [7:0] ADDR_DIGITAL = 8'h02;
   localparam logic [7:0] ADDR_VOLCFG = 8'h03;
   localparam logic [7:0] ADDR_VOL_L = 8'h04;
   localparam logic [7:0] ADDR_VOL_R = 8'h05;

   // reset values, and what an unmapped offset reads
   localparam logic [7:0] RST_POWER = 8'hfd;
   localparam logic [7:0] RST_DIGITAL = 8'h14;
   localparam logic [7:0] RST_VOLCFG = 8'h80;
   localparam logic [7:0] RST_VOLUME = 8'hcf;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // writable bit masks; cleared bits are fixed
   localparam logic [7:0] WMASK_POWER = 8'hff;
   localparam logic [7:0] WMASK_DIGITAL = 8'hbf;
   localparam logic [7:0] WMASK_VOLCFG = 8'h83;
   localparam logic [7:0] WMASK_VOLUME = 8'hff;

   // field positions
   localparam int PWR_CLIP_MSB = 7;
   localparam int PWR_CLIP_LSB = 2;
   localparam int PWR_SLEEP = 1;
   localparam int PWR_RUN = 0;
   localparam int DIG_HPF = 7;
   localparam int DIG_BOOST_MSB = 5;
   localparam int DIG_BOOST_LSB = 4;
   localparam int DIG_SPEED = 3;
   localparam int DIG_FMT_MSB = 2;
   localparam int DIG_FMT_LSB = 0;
   localparam int VCF_FADE = 7;
   localparam int VCF_MUTE_R = 1;
   localparam int VCF_MUTE_L = 0;

   // volume code landmarks and the bass boost step
   localparam logic [7:0] VOL_ZERO_DB = 8'hcf;
   localparam logic [7:0] VOL_MUTE_FLOOR = 8'h07;
   localparam logic [4:0] BOOST_STEP_DB = 5'h06;

   // serial input word lengths
   localparam logic [4:0] BITS_24 = 5'h18;
   localparam logic [4:0] BITS_20 = 5'h14;
   localparam logic [4:0] BITS_18 = 5'h12;
   localparam logic [4:0] BITS_16 = 5'h10;

   typedef enum logic [2:0] {
      FMT_RJ24 = 3'b000,
      FMT_RJ20 = 3'b001,
      FMT_RJ18 = 3'b010,
      FMT_RJ16 = 3'b011,
      FMT_I2S = 3'b100,
      FMT_LJ = 3'b101,
      FMT_RSVD6 = 3'b110,
      FMT_RSVD7 = 3'b111
   } audio_fmt_t;

   typedef struct packed {
      logic [5:0] clip_hi;
      logic sleep;
      logic shutdown;
      logic stage_en;
      logic core_on;
   } power_ctrl_t;

   typedef struct packed {
      logic hpf_bypass;
      logic [4:0] boost_db;
      logic double_speed;
      audio_fmt_t fmt;
      logic fmt_ok;
      logic [4:0] word_bits;
   } path_ctrl_t;

   typedef struct packed {
      logic fade_en;
      logic soft_mute;
      logic vol_mute;
      logic duty_5050;
      logic signed [8:0] gain_half_db;
   } chan_ctrl_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } reg_rsp_t;

endpackage

// ---- design/amp_control_register_bank.sv ----
// control register bank of a stereo serial-input class d amplifier
// assumes the control-port engine hands over single register accesses
// as one-cycle strobes, synchronous to clk
`timescale 1ns/1ps

module amp_control_register_bank #(
   parameter logic [7:0] DEVICE_IDENT = 8'h3c // arbitrary identity value
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // register access from the control port
   input wire amp_ctrl_pkg::reg_req_t req,
   output amp_ctrl_pkg::reg_rsp_t rsp,
   // power and clipper controls
   output amp_ctrl_pkg::power_ctrl_t pwr,
   // digital audio path controls
   output amp_ctrl_pkg::path_ctrl_t path,
   // per-channel controls
   output amp_ctrl_pkg::chan_ctrl_t left,
   output amp_ctrl_pkg::chan_ctrl_t right
);

   // raw registers and all registered outputs travel together
   typedef struct packed {
      logic [7:0] power;
      logic [7:0] digital;
      logic [7:0] volcfg;
      logic [7:0] vol_l;
      logic [7:0] vol_r;
      amp_ctrl_pkg::reg_rsp_t rsp;
      amp_ctrl_pkg::power_ctrl_t pwr;
      amp_ctrl_pkg::path_ctrl_t path;
      amp_ctrl_pkg::chan_ctrl_t left;
      amp_ctrl_pkg::chan_ctrl_t right;
   } bank_state_t;

   // keep writable bits from the new value, fixed bits from the old
   function automatic logic [7:0] merge_write(
      input logic [7:0] old_val,
      input logic [7:0] new_val,
      input logic [7:0] mask
   );
      merge_write = (old_val & ~mask) | (new_val & mask);
   endfunction

   // power register decode
   function automatic amp_ctrl_pkg::power_ctrl_t decode_power(
      input logic [7:0] r
   );
      amp_ctrl_pkg::power_ctrl_t p;
      p.clip_hi = r[amp_ctrl_pkg::PWR_CLIP_MSB:
                    amp_ctrl_pkg::PWR_CLIP_LSB];
      p.sleep = r[amp_ctrl_pkg::PWR_SLEEP];
      p.shutdown = ~r[amp_ctrl_pkg::PWR_RUN];
      // stage runs only when neither shut down nor asleep
      p.stage_en = r[amp_ctrl_pkg::PWR_RUN] &
                   ~r[amp_ctrl_pkg::PWR_SLEEP];
      // low-voltage blocks stay on in sleep, go off in shutdown
      p.core_on = r[amp_ctrl_pkg::PWR_RUN];
      decode_power = p;
   endfunction

   // digital path decode
   function automatic amp_ctrl_pkg::path_ctrl_t decode_path(
      input logic [7:0] r
   );
      amp_ctrl_pkg::path_ctrl_t d;
      logic [1:0] boost;
      boost = r[amp_ctrl_pkg::DIG_BOOST_MSB:amp_ctrl_pkg::DIG_BOOST_LSB];
      d.hpf_bypass = r[amp_ctrl_pkg::DIG_HPF];
      d.boost_db = 5'(boost * amp_ctrl_pkg::BOOST_STEP_DB);
      d.double_speed = r[amp_ctrl_pkg::DIG_SPEED];
      d.fmt = amp_ctrl_pkg::audio_fmt_t'(
         r[amp_ctrl_pkg::DIG_FMT_MSB:amp_ctrl_pkg::DIG_FMT_LSB]);
      d.fmt_ok = 1'b1;
      // justified formats carry a fixed word, i2s and lj run to 24
      unique case (d.fmt)
         amp_ctrl_pkg::FMT_RJ24: d.word_bits = amp_ctrl_pkg::BITS_24;
         amp_ctrl_pkg::FMT_RJ20: d.word_bits = amp_ctrl_pkg::BITS_20;
         amp_ctrl_pkg::FMT_RJ18: d.word_bits = amp_ctrl_pkg::BITS_18;
         amp_ctrl_pkg::FMT_RJ16: d.word_bits = amp_ctrl_pkg::BITS_16;
         amp_ctrl_pkg::FMT_I2S: d.word_bits = amp_ctrl_pkg::BITS_24;
         amp_ctrl_pkg::FMT_LJ: d.word_bits = amp_ctrl_pkg::BITS_24;
         default: begin
            // reserved codes: flagged, audio path must not trust it
            d.fmt_ok = 1'b0;
            d.word_bits = amp_ctrl_pkg::BITS_24;
         end
      endcase
      decode_path = d;
   endfunction

   // one channel: volume code, soft mute and fade together
   function automatic amp_ctrl_pkg::chan_ctrl_t decode_chan(
      input logic [7:0] code,
      input logic soft_mute,
      input logic fade,
      input logic stage_en
   );
      amp_ctrl_pkg::chan_ctrl_t c;
      c.fade_en = fade;
      c.soft_mute = soft_mute;
      c.vol_mute = (code < amp_ctrl_pkg::VOL_MUTE_FLOOR);
      // 50/50 only while the stage switches; sleep already idles it
      c.duty_5050 = (soft_mute | c.vol_mute) & stage_en;
      c.gain_half_db = $signed({1'b0, code}) -
                       $signed({1'b0, amp_ctrl_pkg::VOL_ZERO_DB});
      decode_chan = c;
   endfunction

   // fill every decoded field from the raw registers
   function automatic bank_state_t decode_all(input bank_state_t s);
      bank_state_t o;
      o = s;
      o.pwr = decode_power(s.power);
      o.path = decode_path(s.digital);
      o.left = decode_chan(s.vol_l, s.volcfg[amp_ctrl_pkg::VCF_MUTE_L],
                           s.volcfg[amp_ctrl_pkg::VCF_FADE],
                           o.pwr.stage_en);
      o.right = decode_chan(s.vol_r, s.volcfg[amp_ctrl_pkg::VCF_MUTE_R],
                            s.volcfg[amp_ctrl_pkg::VCF_FADE],
                            o.pwr.stage_en);
      decode_all = o;
   endfunction

   // raw reset image, then decoded outputs derived from it
   function automatic bank_state_t reset_state();
      bank_state_t s;
      s = '0;
      s.power = amp_ctrl_pkg::RST_POWER;
      s.digital = amp_ctrl_pkg::RST_DIGITAL;
      s.volcfg = amp_ctrl_pkg::RST_VOLCFG;
      s.vol_l = amp_ctrl_pkg::RST_VOLUME;
      s.vol_r = amp_ctrl_pkg::RST_VOLUME;
      reset_state = decode_all(s);
   endfunction

   localparam bank_state_t ST_RESET = reset_state();

   // read mux; an unmapped offset reads as zero
   function automatic logic [7:0] read_reg(
      input logic [7:0] addr,
      input bank_state_t s
   );
      unique case (addr)
         amp_ctrl_pkg::ADDR_IDENT: read_reg = DEVICE_IDENT;
         amp_ctrl_pkg::ADDR_POWER: read_reg = s.power;
         amp_ctrl_pkg::ADDR_DIGITAL: read_reg = s.digital;
         amp_ctrl_pkg::ADDR_VOLCFG: read_reg = s.volcfg;
         amp_ctrl_pkg::ADDR_VOL_L: read_reg = s.vol_l;
         amp_ctrl_pkg::ADDR_VOL_R: read_reg = s.vol_r;
         default: read_reg = amp_ctrl_pkg::READ_UNMAPPED;
      endcase
   endfunction

   bank_state_t st_ff;
   bank_state_t nxt_st;

   // next state: read answer, writes, then re-decode outputs
   always_comb begin
      nxt_st = st_ff;
      // read sees contents before a write in the same cycle
      nxt_st.rsp.valid = req.rd;
      nxt_st.rsp.rdata = req.rd ? read_reg(req.addr, st_ff)
                                : st_ff.rsp.rdata;
      if (req.wr) begin
         // identity offset has no storage, so writes there vanish
         unique case (req.addr)
            amp_ctrl_pkg::ADDR_POWER: begin
               nxt_st.power = merge_write(st_ff.power, req.wdata,
                                          amp_ctrl_pkg::WMASK_POWER);
            end
            amp_ctrl_pkg::ADDR_DIGITAL: begin
               nxt_st.digital = merge_write(st_ff.digital, req.wdata,
                                            amp_ctrl_pkg::WMASK_DIGITAL);
            end
            amp_ctrl_pkg::ADDR_VOLCFG: begin
               nxt_st.volcfg = merge_write(st_ff.volcfg, req.wdata,
                                           amp_ctrl_pkg::WMASK_VOLCFG);
            end
            amp_ctrl_pkg::ADDR_VOL_L: begin
               nxt_st.vol_l = merge_write(st_ff.vol_l, req.wdata,
                                          amp_ctrl_pkg::WMASK_VOLUME);
            end
            amp_ctrl_pkg::ADDR_VOL_R: begin
               nxt_st.vol_r = merge_write(st_ff.vol_r, req.wdata,
                                          amp_ctrl_pkg::WMASK_VOLUME);
            end
            default: begin
               nxt_st.power = st_ff.power;
            end
         endcase
      end
      // outputs follow the new contents at the same edge
      nxt_st = decode_all(nxt_st);
   end

   // single state register; low enable freezes everything
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= ST_RESET;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // all outputs straight from the state register
   assign rsp = st_ff.rsp;
   assign pwr = st_ff.pwr;
   assign path = st_ff.path;
   assign left = st_ff.left;
   assign right = st_ff.right;

endmodule

// ---- dv/amp_bank_monitor.sv ----
// port checker of the amplifier control bank
// assumes rising clk, async active-high rst, bound into the bank
`timescale 1ns/1ps
module amp_bank_monitor #(
   parameter logic [7:0] DEVICE_IDENT = 8'h3c // arbitrary identity value
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // register port
   input wire amp_ctrl_pkg::reg_req_t req,
   input wire amp_ctrl_pkg::reg_rsp_t rsp,
   // decoded controls
   input wire amp_ctrl_pkg::power_ctrl_t pwr,
   input wire amp_ctrl_pkg::path_ctrl_t path,
   input wire amp_ctrl_pkg::chan_ctrl_t left,
   input wire amp_ctrl_pkg::chan_ctrl_t right
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // strobes only count when the clock enable lets them in
   logic wr_go;
   logic rd_go;
   assign wr_go = ce & req.wr;
   assign rd_go = ce & req.rd;
   property p_ident;
      rd_go && req.addr == 8'h00 |=> rsp.valid && rsp.rdata == DEVICE_IDENT;
   endproperty
   a_ident: assert property (p_ident) else $error("ident");
   property p_power;
      wr_go && req.addr == 8'h01 |=>
         {pwr.clip_hi, pwr.sleep, pwr.core_on} == $past(req.wdata) &&
         pwr.stage_en == ($past(req.wdata[0]) && !$past(req.wdata[1]));
   endproperty
   a_power: assert property (p_power) else $error("power");
   property p_boost;
      wr_go && req.addr == 8'h02 |=> path.hpf_bypass == $past(req.wdata[7])
         && path.boost_db == 5'd6 * $past(req.wdata[5:4]);
   endproperty
   a_boost: assert property (p_boost) else $error("boost");
   property p_format;
      wr_go && req.addr == 8'h02 |=> path.fmt == $past(req.wdata[2:0]) &&
         path.double_speed == $past(req.wdata[3]) &&
         path.fmt_ok == ($past(req.wdata[2:0]) <= 3'd5);
   endproperty
   a_format: assert property (p_format) else $error("format");
   property p_fixed;
      rd_go && req.addr == 8'h02 |=> rsp.valid && !rsp.rdata[6];
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed bit");
   property p_volcfg;
      wr_go && req.addr == 8'h03 |=> left.fade_en == $past(req.wdata[7]) &&
         right.soft_mute == $past(req.wdata[1]) &&
         left.soft_mute == $past(req.wdata[0]);
   endproperty
   a_volcfg: assert property (p_volcfg) else $error("mute");
   property p_left;
      wr_go && req.addr == 8'h04 |=> left.vol_mute == ($past(req.wdata) <
         8'h07) && left.gain_half_db == {1'b0, $past(req.wdata)} - 9'h0cf;
   endproperty
   a_left: assert property (p_left) else $error("left");
   property p_right;
      wr_go && req.addr == 8'h05 |=> right.vol_mute == ($past(req.wdata) <
         8'h07) && right.gain_half_db == {1'b0, $past(req.wdata)} - 9'h0cf;
   endproperty
   a_right: assert property (p_right) else $error("right");
   // sleep or shutdown must keep the power stage off
   property p_stage;
      pwr.sleep || pwr.shutdown |-> !pwr.stage_en;
   endproperty
   a_stage: assert property (p_stage) else $error("stage");
   // no 50/50 switching while the stage is idle
   property p_quiet;
      !pwr.stage_en |-> !left.duty_5050 && !right.duty_5050;
   endproperty
   a_quiet: assert property (p_quiet) else $error("duty");
   // read answer is a single-cycle pulse
   property p_pulse;
      ce && !req.rd |=> !rsp.valid;
   endproperty
   a_pulse: assert property (p_pulse) else $error("valid");
   // main scenarios reached
   c_ident: cover property (rd_go && req.addr == 8'h00);
   c_mute: cover property (wr_go && req.addr == 8'h04 && req.wdata < 8'h07);
   c_back: cover property (rd_go ##1 rd_go);
   c_sleep: cover property (pwr.sleep && pwr.core_on);
endmodule
bind amp_control_register_bank amp_bank_monitor #(
   .DEVICE_IDENT(DEVICE_IDENT)) amp_bank_monitor_i (.clk(clk), .rst(rst),
   .ce(ce), .req(req), .rsp(rsp), .pwr(pwr), .path(path), .left(left),
   .right(right));

// ---- dv/ctrl_port_host.sv ----
// host model of the control port, one register access at a time
// assumes its tasks are entered at a falling clk edge
`timescale 1ns/1ps
module ctrl_port_host (
   // clock
   input wire logic clk,
   // register port toward the bank
   output amp_ctrl_pkg::reg_req_t req,
   input wire amp_ctrl_pkg::reg_rsp_t rsp
);
   initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
   // strobes held over one rising edge; answer taken at the next fall
   task automatic xfer(input logic w, input logic r, input logic [7:0] a,
      input logic [7:0] d, input logic keep,
      output amp_ctrl_pkg::reg_rsp_t got);
      logic [7:0] v;
      v = d;
      // well-behaved software keeps fixed bits and legal formats
      if (keep && a == 8'h02) begin
         v[6] = 1'b0;
         if (v[2:0] > 3'b101) v[2:0] = 3'b101;
      end
      if (keep && a == 8'h03) v[6:2] = 5'h00;
      req = '{wr: w, rd: r, addr: a, wdata: v};
      @(negedge clk);
      got = rsp;
   endtask
   // released lines toggle so a stale value cannot pass
   task automatic idle();
      req = '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
      @(negedge clk);
   endtask
endmodule

// ---- dv/amp_control_register_bank_test.sv ----
// self-checking bench of the amplifier control bank
// assumes the host model drives the port at falling clk edges
`timescale 1ns/1ps
module amp_control_register_bank_test;
   localparam logic [7:0] ID = 8'h5a; // arbitrary identity value
   localparam logic [7:0] RV [7] = '{ID, 8'hfd, 8'h14, 8'h80, 8'hcf,
      8'hcf, 8'h00};
   localparam logic [7:0] PV [4] = '{8'h00, 8'h03, 8'hfe, 8'h81};
   localparam logic [7:0] VC [5] = '{8'hff, 8'hcf, 8'h07, 8'h06, 8'h00};
   localparam logic [4:0] BST [4] = '{5'd0, 5'd6, 5'd12, 5'd18};
   localparam logic [4:0] WB [6] = '{5'd24, 5'd20, 5'd18, 5'd16, 5'd24,
      5'd24};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   int num_errors = 0;
   int num_checks = 0;
   logic [7:0] v;
   amp_ctrl_pkg::reg_req_t req;
   amp_ctrl_pkg::reg_rsp_t rsp;
   amp_ctrl_pkg::reg_rsp_t got;
   amp_ctrl_pkg::power_ctrl_t pwr;
   amp_ctrl_pkg::path_ctrl_t path;
   amp_ctrl_pkg::chan_ctrl_t left;
   amp_ctrl_pkg::chan_ctrl_t right;
   // 10 mhz clock
   always #50 clk = ~clk;
   amp_control_register_bank #(.DEVICE_IDENT(ID))
      amp_control_register_bank_i (.clk(clk), .rst(rst), .ce(ce),
      .req(req), .rsp(rsp), .pwr(pwr), .path(path), .left(left),
      .right(right));
   ctrl_port_host ctrl_port_host_i (.clk(clk), .req(req), .rsp(rsp));
   // single compare, values widened to nine bits
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic keep);
      ctrl_port_host_i.xfer(1'b1, 1'b0, a, d, keep, got);
      ctrl_port_host_i.idle();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      ctrl_port_host_i.xfer(1'b0, 1'b1, a, 8'h00, 1'b1, got);
      ctrl_port_host_i.idle();
      chk({got.valid, got.rdata}, {1'b1, e});
   endtask
   task automatic t_reset();
      foreach (RV[i]) rd(i[7:0], RV[i]);
      chk({pwr.clip_hi, pwr.sleep, pwr.shutdown, pwr.stage_en}, 9'h1f9);
      chk({path.boost_db, path.fmt}, {5'd6, 3'b100});
      chk(left.gain_half_db, 9'h000);
   endtask
   task automatic t_power();
      foreach (PV[i]) begin
         wr(8'h01, PV[i], 1'b1);
         chk({pwr.clip_hi, pwr.sleep, pwr.core_on}, PV[i]);
         chk({pwr.shutdown, pwr.stage_en},
            {~PV[i][0], PV[i][0] & ~PV[i][1]});
         rd(8'h01, PV[i]);
      end
   endtask
   task automatic t_digital();
      for (int k = 0; k < 6; k++) begin
         v = {k[0], 1'b0, k[1:0], k[1], k[2:0]};
         wr(8'h02, v, 1'b1);
         chk({path.hpf_bypass, path.double_speed, path.fmt},
            {v[7], v[3], v[2:0]});
         chk(path.boost_db, BST[k[1:0]]);
         chk({path.fmt_ok, path.word_bits}, {1'b1, WB[k]});
      end
      wr(8'h02, 8'hff, 1'b0);
      rd(8'h02, 8'hbf);
      chk({path.fmt_ok, path.word_bits}, {1'b0, 5'd24});
   endtask
   task automatic t_volume();
      wr(8'h03, 8'hff, 1'b0);
      rd(8'h03, 8'h83);
      chk({left.fade_en, left.soft_mute, right.soft_mute, left.duty_5050,
         right.duty_5050}, 9'h01f);
      wr(8'h03, 8'h02, 1'b1);
      chk({left.fade_en, left.soft_mute, right.soft_mute, left.duty_5050,
         right.duty_5050}, 9'h005);
      // asleep: mute is reported but the idle stage does not switch
      wr(8'h01, 8'h03, 1'b1);
      chk({right.soft_mute, right.duty_5050}, 9'h002);
      wr(8'h01, 8'hfd, 1'b1);
      foreach (VC[i]) begin
         wr(8'h04, VC[i], 1'b1);
         wr(8'h05, ~VC[i], 1'b1);
         chk(left.gain_half_db, {1'b0, VC[i]} - 9'h0cf);
         chk({left.vol_mute, left.duty_5050}, {2{VC[i] < 8'h07}});
         chk(right.gain_half_db, {1'b0, ~VC[i]} - 9'h0cf);
         rd(8'h04, VC[i]);
      end
   endtask
   // ident write, frozen enable, write and read in one cycle
   task automatic t_edge();
      wr(8'h00, 8'hff, 1'b1);
      rd(8'h00, ID);
      ce = 1'b0;
      wr(8'h04, 8'h10, 1'b1);
      ce = 1'b1;
      rd(8'h04, 8'h00);
      ctrl_port_host_i.xfer(1'b1, 1'b1, 8'h05, 8'h42, 1'b1, got);
      chk({got.valid, got.rdata}, 9'h1ff);
      ctrl_port_host_i.xfer(1'b0, 1'b1, 8'h05, 8'h00, 1'b1, got);
      chk({got.valid, got.rdata}, 9'h142);
      ctrl_port_host_i.idle();
   endtask
   // mid-run reset brings every register back to its default
   task automatic t_rerun();
      rst = 1'b1;
      repeat (2) @(negedge clk);
      chk(right.gain_half_db, 9'h000);
      rst = 1'b0;
      rd(8'h05, 8'hcf);
      rd(8'h04, 8'hcf);
      rd(8'h03, 8'h80);
      rd(8'h02, 8'h14);
      chk({pwr.clip_hi, pwr.sleep, pwr.shutdown, pwr.stage_en}, 9'h1f9);
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_power();
      t_digital();
      t_volume();
      t_edge();
      t_rerun();
      stop_test();
   end
   // watchdog against a hung run
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      stop_test();
   end
endmodule
